// *** common/node_cfg_map.vh ***
// constants for the fieldbus node configuration and status block
// assumes inclusion by bare name from design files; definitions only
`ifndef NODE_CFG_MAP_VH
`define NODE_CFG_MAP_VH

// largest station address the switches may select directly
`define ADDR_SW_MAX        7'h3F
// stored station address after reset, forces switch or bus setup
`define STORED_ADDR_RST    7'h3F
// largest bit-rate code the switch may select directly
`define RATE_SW_MAX        2'h2
// bit-rate codes
`define RATE_125K          2'h0
`define RATE_250K          2'h1
`define RATE_500K          2'h2
// bus object identifiers
`define OBJ_CLASS_LINK     8'h03
`define OBJ_ATTR_ADDR      8'h01
`define OBJ_ATTR_RATE      8'h02
`define OBJ_CLASS_STORE    8'h25
`define OBJ_ATTR_SAVE      8'h65
// led codes: off, green, blink green, blink red, red
`define LED_OFF            3'h0
`define LED_GREEN          3'h1
`define LED_GREEN_BLINK    3'h2
`define LED_RED_BLINK      3'h3
`define LED_RED            3'h4
// register indices on the plain register port
`define REG_CTRL           4'h0
`define REG_STATUS         4'h1
`define REG_STORED_ADDR    4'h2
`define REG_STORED_RATE    4'h3
`define REG_ACTIVE         4'h4
`define REG_LED            4'h5
// control register bit positions
`define CTRL_ONLINE        0
`define CTRL_DUP_DONE      1
`define CTRL_CONN          2
`define CTRL_MASTER        3
`define CTRL_CFG_OK        4
`define CTRL_RECOV_ERR     5
`define CTRL_IO_WAIT       6
`define CTRL_FATAL         7
`define CTRL_DUP_FOUND     8
`define CTRL_BUS_OFF       9
// status bit positions
`define STAT_PEND_ADDR     0
`define STAT_PEND_RATE     1
`define STAT_SAVED         2
// blink half period in ns and in 10 ns clock cycles
`define BLINK_HALF_NS      500000000
`define CLK_PERIOD_NS      10
`define BLINK_HALF_CYC     (`BLINK_HALF_NS / `CLK_PERIOD_NS)

`endif

// *** design/blink_gen.v ***
// free-running blink phase generator for the status led
// assumes one clock; half period given in cycles by parameter
`timescale 1ns/100ps
module blink_gen #(
    parameter HALF_CYC = 50000000   // cycles per half period
) (
    input  wire clk_sys,            // system clock
    input  wire rst,                // synchronous reset, active high
    output reg  phase_reg           // blink phase, high = lit
);
    reg [31:0] cnt_reg;             // half period counter

    // count cycles, toggle phase at each half period
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_reg   <= 32'h0;
            phase_reg <= 1'b0;
        end else if (cnt_reg >= HALF_CYC - 1) begin
            cnt_reg   <= 32'h0;
            phase_reg <= ~phase_reg;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end
endmodule

// *** design/node_cfg_status.v ***
// station address, bit rate and combined status led of a fieldbus node
// assumes one clock; switches and node state come from outside
// (switches are pins, synchronised here); firmware uses register port
//
// Behaviour
// - led dark until online after address check, except when a steady red fault is set
// - steady green when fully operational with master
// - blink green when online but not configured
// - blink red on recoverable error or timeout
// - steady red on fatal fault or bus-off
// - switches 0..63 give address directly
// - switches above 63 use stored address
// - bus may write address when switches above 63
// - rate switch 0,1,2 gives 125/250/500 kbit/s
// - rate switch above 2 uses stored rate
// - bus may write rate code 0..2
// - bus changes apply after save and restart
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "node_cfg_map.vh"
module node_cfg_status #(
    parameter BLINK_HALF = `BLINK_HALF_CYC  // blink half period, cycles
) (
    input  wire       clk_sys,          // system clock, 100 MHz
    input  wire       rst,              // synchronous reset, active high
    input  wire [3:0] address_tens_switch,  // tens digit, bcd
    input  wire [3:0] address_units_switch, // units digit, bcd
    input  wire [3:0] rate_switch,      // bit-rate switch value
    input  wire       drive_restart_cmd,    // restart pulse from firmware
    input  wire       obj_wr,           // bus object write strobe
    input  wire [7:0] obj_class,        // bus object class
    input  wire [7:0] obj_attr,         // bus object attribute
    input  wire [7:0] obj_data,         // bus object data
    input  wire [3:0] reg_addr,         // register index
    input  wire [15:0] reg_wdata,       // register write data
    input  wire       reg_wr,           // register write strobe
    input  wire       reg_rd,           // register read strobe
    output reg  [15:0] reg_rdata,       // read data, cycle after strobe
    output reg  [6:0] station_address,  // address in use
    output reg  [1:0] bit_rate,         // rate code in use
    output reg        led_green,        // status led green element
    output reg        led_red           // status led red element
);
    // synchroniser stages for switch pins
    reg [11:0] sw_s1_reg;               // first stage, read only by second
    reg [11:0] sw_s2_reg;               // second stage
    // software registers
    reg [9:0]  ctrl_reg;                // node state bits from firmware
    reg [6:0]  stored_addr_reg;         // stored station address
    reg [1:0]  stored_rate_reg;         // stored bit-rate code
    reg [6:0]  pend_addr_reg;           // bus-written address, not yet saved
    reg [1:0]  pend_rate_reg;           // bus-written rate, not yet saved
    reg        pend_addr_v_reg;         // pending address valid
    reg        pend_rate_v_reg;         // pending rate valid
    reg        saved_reg;               // save seen since last restart
    reg [2:0]  led_state_reg;           // current led code
    // combinational
    reg [2:0]  led_state_next;          // next led code
    wire [6:0] sw_addr;                 // decoded switch address
    wire       sw_addr_ok;              // switches within direct range
    wire       sw_rate_ok;              // rate switch within direct range
    wire       blink_phase;             // shared blink phase
    wire       store_save;              // save request from bus

    // bcd digits to binary address
    function [6:0] bcd_to_bin;
        input [3:0] tens;
        input [3:0] units;
        begin
            // keep all four tens bits: 80 and 90 must not wrap into range
            bcd_to_bin = {tens[3:0], 3'h0} + {2'h0, tens[3:0], 1'h0}
                         + {3'h0, units};
        end
    endfunction

    // decode whether a bus write hits given class and attribute
    function obj_hit;
        input [7:0] cls;
        input [7:0] att;
        input [7:0] want_cls;
        input [7:0] want_att;
        begin
            obj_hit = (cls == want_cls) && (att == want_att);
        end
    endfunction

    blink_gen #(
        .HALF_CYC (BLINK_HALF)
    ) u_blink (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .phase_reg (blink_phase)
    );

    // two-flop synchroniser for all switch pins
    always @(posedge clk_sys) begin
        if (rst) begin
            sw_s1_reg <= 12'h0;
            sw_s2_reg <= 12'h0;
        end else begin
            sw_s1_reg <= {rate_switch, address_tens_switch,
                          address_units_switch};
            sw_s2_reg <= sw_s1_reg;
        end
    end

    // tens above 9 or units above 9 count as out of range
    assign sw_addr    = bcd_to_bin(sw_s2_reg[7:4], sw_s2_reg[3:0]);
    assign sw_addr_ok = (sw_s2_reg[7:4] <= 4'h9) && (sw_s2_reg[3:0] <= 4'h9)
                        && (sw_addr <= `ADDR_SW_MAX);
    assign sw_rate_ok = (sw_s2_reg[11:8] <= {2'h0, `RATE_SW_MAX});
    assign store_save = obj_wr && obj_hit(obj_class, obj_attr,
                        `OBJ_CLASS_STORE, `OBJ_ATTR_SAVE);

    // register writes, bus object writes and save/restart sequence
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg        <= 10'h0;
            stored_addr_reg <= `STORED_ADDR_RST;
            stored_rate_reg <= `RATE_125K;
            pend_addr_reg   <= 7'h0;
            pend_rate_reg   <= `RATE_125K;
            pend_addr_v_reg <= 1'b0;
            pend_rate_v_reg <= 1'b0;
            saved_reg       <= 1'b0;
        end else begin
            // firmware register writes
            if (reg_wr) begin
                case (reg_addr)
                    `REG_CTRL: begin
                        ctrl_reg <= reg_wdata[9:0];
                    end
                    `REG_STORED_ADDR: begin
                        stored_addr_reg <= reg_wdata[6:0];
                    end
                    `REG_STORED_RATE: begin
                        if (reg_wdata[1:0] <= `RATE_SW_MAX) begin
                            stored_rate_reg <= reg_wdata[1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // bus address write only honoured with switches out of range
            if (obj_wr && !sw_addr_ok && obj_hit(obj_class, obj_attr,
                `OBJ_CLASS_LINK, `OBJ_ATTR_ADDR)
                && obj_data[6:0] <= `ADDR_SW_MAX && obj_data[7] == 1'b0) begin
                pend_addr_reg   <= obj_data[6:0];
                pend_addr_v_reg <= 1'b1;
            end
            // bus rate write, code 0..2 only
            if (obj_wr && !sw_rate_ok && obj_hit(obj_class, obj_attr,
                `OBJ_CLASS_LINK, `OBJ_ATTR_RATE)
                && obj_data <= {6'h0, `RATE_SW_MAX}) begin
                pend_rate_reg   <= obj_data[1:0];
                pend_rate_v_reg <= 1'b1;
            end
            // save copies pending values into storage
            if (store_save) begin
                saved_reg <= 1'b1;
                if (pend_addr_v_reg) begin
                    stored_addr_reg <= pend_addr_reg;
                    pend_addr_v_reg <= 1'b0;
                end
                if (pend_rate_v_reg) begin
                    stored_rate_reg <= pend_rate_reg;
                    pend_rate_v_reg <= 1'b0;
                end
            end else if (drive_restart_cmd) begin
                saved_reg <= 1'b0;
            end
        end
    end

    // values in use latched only at restart; reset loads address 0 and rate 125K
    always @(posedge clk_sys) begin
        if (rst) begin
            station_address <= 7'h0;
            bit_rate        <= `RATE_125K;
        end else if (drive_restart_cmd) begin
            if (sw_addr_ok) begin
                station_address <= sw_addr;
            end else begin
                station_address <= stored_addr_reg;
            end
            if (sw_rate_ok) begin
                bit_rate <= sw_s2_reg[9:8];
            end else begin
                bit_rate <= stored_rate_reg;
            end
        end
    end

    // led state with fixed priority
    always @* begin
        if (ctrl_reg[`CTRL_FATAL] || ctrl_reg[`CTRL_DUP_FOUND]
            || ctrl_reg[`CTRL_BUS_OFF]) begin
            led_state_next = `LED_RED;
        end else if (!ctrl_reg[`CTRL_ONLINE]
                     || !ctrl_reg[`CTRL_DUP_DONE]) begin
            led_state_next = `LED_OFF;
        end else if (ctrl_reg[`CTRL_RECOV_ERR]
                     || ctrl_reg[`CTRL_IO_WAIT]) begin
            led_state_next = `LED_RED_BLINK;
        end else if (!ctrl_reg[`CTRL_CONN] || !ctrl_reg[`CTRL_MASTER]
                     || !ctrl_reg[`CTRL_CFG_OK]) begin
            led_state_next = `LED_GREEN_BLINK;
        end else begin
            led_state_next = `LED_GREEN;
        end
    end

    // drive led elements from registers
    always @(posedge clk_sys) begin
        if (rst) begin
            led_state_reg <= `LED_OFF;
            led_green     <= 1'b0;
            led_red       <= 1'b0;
        end else begin
            led_state_reg <= led_state_next;
            case (led_state_next)
                `LED_GREEN: begin
                    led_green <= 1'b1;
                    led_red   <= 1'b0;
                end
                `LED_GREEN_BLINK: begin
                    led_green <= blink_phase;
                    led_red   <= 1'b0;
                end
                `LED_RED_BLINK: begin
                    led_green <= 1'b0;
                    led_red   <= blink_phase;
                end
                `LED_RED: begin
                    led_green <= 1'b0;
                    led_red   <= 1'b1;
                end
                default: begin
                    led_green <= 1'b0;
                    led_red   <= 1'b0;
                end
            endcase
        end
    end

    // register read port, data one cycle after strobe
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 16'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL:        reg_rdata <= {6'h0, ctrl_reg};
                `REG_STATUS:      reg_rdata <= {13'h0, saved_reg,
                                      pend_rate_v_reg, pend_addr_v_reg};
                `REG_STORED_ADDR: reg_rdata <= {9'h0, stored_addr_reg};
                `REG_STORED_RATE: reg_rdata <= {14'h0, stored_rate_reg};
                `REG_ACTIVE:      reg_rdata <= {7'h0, bit_rate,
                                      station_address};
                `REG_LED:         reg_rdata <= {13'h0, led_state_reg};
                default:          reg_rdata <= 16'h0;
            endcase
        end else begin
            reg_rdata <= 16'h0;
        end
    end
endmodule

// *** bench/node_cfg_status_asserts.sv ***
// assertions on the node configuration and status block
// assumes binding to node_cfg_status; sees its ports only
`timescale 1ns/100ps
module node_cfg_status_chk (
    input logic        clk_sys,
    input logic        rst,
    input logic [3:0]  address_tens_switch,
    input logic [3:0]  address_units_switch,
    input logic [3:0]  rate_switch,
    input logic        drive_restart_cmd,
    input logic [3:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_wr,
    input logic [6:0]  station_address,
    input logic [1:0]  bit_rate,
    input logic        led_green,
    input logic        led_red
);
    logic [9:0] ctrl_q;                   // copy of node state
    logic [3:0] tens_q, units_q, rate_q;  // switches one edge ago
    logic [1:0] age;                      // edges switches stood
    logic [7:0] sw_val;                   // decimal switch value
    logic       sw_ok, fault, up, well, err; // decoded conditions
    assign sw_val = tens_q * 8'h0A + units_q;
    assign sw_ok = tens_q <= 4'h9 && units_q <= 4'h9 && sw_val <= 8'h3F;
    assign fault = |ctrl_q[9:7];
    assign up = ctrl_q[0] & ctrl_q[1] & !fault;
    assign well = &ctrl_q[4:2];
    assign err = |ctrl_q[6:5];
    // mirror state writes, time how long switches stood
    always @(posedge clk_sys) begin
        {tens_q, units_q, rate_q} <= {address_tens_switch,
            address_units_switch, rate_switch};
        if (rst) begin
            ctrl_q <= 10'h000;
            age <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == 4'h0)
                ctrl_q <= reg_wdata[9:0];
            if ({tens_q, units_q, rate_q} != {address_tens_switch,
                address_units_switch, rate_switch})
                age <= 2'h0;
            else if (age != 2'h3)
                age <= age + 2'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_red_fault: assert property (fault |=> led_red && !led_green)
        else $error("no steady red on fault");
    a_dark_offline: assert property (!fault && !up
        |=> !led_red && !led_green) else $error("led lit while offline");
    a_steady_green: assert property (up && well && !err
        |=> led_green && !led_red) else $error("no steady green");
    a_blink_green: assert property (up && !well && !err |=> !led_red)
        else $error("red lit on idle node");
    a_blink_red: assert property (up && err |=> !led_green)
        else $error("green lit during error");
    a_switch_addr: assert property (drive_restart_cmd && age == 2'h3
        && sw_ok |=> {1'b0, station_address} == $past(sw_val))
        else $error("bad address");
    a_switch_rate: assert property (drive_restart_cmd && age == 2'h3
        && rate_q <= 4'h2 |=> {2'h0, bit_rate} == $past(rate_q))
        else $error("bad bit rate");
    a_apply_restart: assert property ($changed(station_address)
        || $changed(bit_rate) |-> $past(drive_restart_cmd) || $past(rst))
        else $error("setting changed without restart");
endmodule
bind node_cfg_status node_cfg_status_chk chk (.clk_sys, .rst,
    .address_tens_switch, .address_units_switch, .rate_switch,
    .drive_restart_cmd, .reg_addr, .reg_wdata, .reg_wr,
    .station_address, .bit_rate, .led_green, .led_red);

// *** bench/net_master_model.sv ***
// network master model writing bus objects to the node
// assumes the bench raises send for one cycle per write
`timescale 1ns/100ps
module net_master_model (
    input  logic       clk_sys,
    input  logic       send,
    input  logic [7:0] s_cls,
    input  logic [7:0] s_att,
    input  logic [7:0] s_dat,
    output logic       obj_wr,
    output logic [7:0] obj_class,
    output logic [7:0] obj_attr,
    output logic [7:0] obj_data
);
    // lines start low; only the strobe stays low before a write
    initial {obj_wr, obj_class, obj_attr, obj_data} = 25'h0000000;
    // one write cycle per send; released lines stop holding
    always @(posedge clk_sys) begin
        obj_wr <= send;
        if (send)
            {obj_class, obj_attr, obj_data} <= {s_cls, s_att, s_dat};
        else
            {obj_class, obj_attr, obj_data} <= ~{obj_class, obj_attr,
                obj_data};
    end
endmodule

// *** bench/tb_node_cfg_status.sv ***
// bench for the node configuration and status block
// assumes master model and checker compile before it
`timescale 1ns/100ps
`include "node_cfg_map.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_node_cfg_status;
    logic        clk_sys = 1'b0;              // system clock
    logic        rst = 1'b1;                  // reset
    logic [3:0]  address_tens_switch = 4'h0;  // tens digit
    logic [3:0]  address_units_switch = 4'h0; // units digit
    logic [3:0]  rate_switch = 4'h0;          // rate switch
    logic        drive_restart_cmd = 1'b0;    // restart pulse
    logic        send = 1'b0;                 // master request
    logic [7:0]  s_cls = 8'h00, s_att = 8'h00, s_dat = 8'h00; // object
    logic        obj_wr;                      // object strobe
    logic [7:0]  obj_class, obj_attr, obj_data; // object fields
    logic [3:0]  reg_addr = 4'h0;             // register index
    logic [15:0] reg_wdata = 16'h0000;        // write data
    logic        reg_wr = 1'b0, reg_rd = 1'b0; // strobes
    logic [15:0] reg_rdata;                   // read data
    logic [6:0]  station_address;             // address in use
    logic [1:0]  bit_rate;                    // rate in use
    logic        led_green, led_red;          // led elements
    int          n_tests = 0, miscompares = 0; // tallies
    node_cfg_status #(.BLINK_HALF(4)) DUT (.clk_sys, .rst,
        .address_tens_switch, .address_units_switch, .rate_switch,
        .drive_restart_cmd, .obj_wr, .obj_class, .obj_attr, .obj_data,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .station_address, .bit_rate, .led_green, .led_red);
    net_master_model master (.clk_sys, .send, .s_cls, .s_att, .s_dat,
        .obj_wr, .obj_class, .obj_attr, .obj_data);
    // clock
    always #5 clk_sys = ~clk_sys;
    task automatic results;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // read, compare data in the cycle after the strobe
    task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        `CHK(d, e)
    endtask
    task automatic set_sw(input logic [3:0] t, u, r);
        @(posedge clk_sys);
        {address_tens_switch, address_units_switch, rate_switch} <= {t, u, r};
    endtask
    // restart once the switch synchroniser has settled
    // five edges so the checker also sees the switches as settled
    task automatic restart;
        repeat (5) @(posedge clk_sys);
        drive_restart_cmd <= 1'b1;
        @(posedge clk_sys);
        drive_restart_cmd <= 1'b0;
        #1;
    endtask
    task automatic obj(input logic [7:0] c, a, d);
        @(posedge clk_sys);
        {send, s_cls, s_att, s_dat} <= {1'b1, c, a, d};
        @(posedge clk_sys);
        send <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic t_reset;
        `CHK({station_address, bit_rate, led_green, led_red}, 11'h000)
        chk_rd(`REG_STORED_ADDR, 16'h003F);
        chk_rd(`REG_STORED_RATE, 16'h0000);
        chk_rd(4'hF, 16'h0000);
    endtask
    // in-range switches taken as they stand, 63 included
    task automatic t_switch;
        logic [3:0] tv [3] = '{4'h1, 4'h6, 4'h4};
        logic [3:0] uv [3] = '{4'h0, 4'h3, 4'h2};
        for (int i = 0; i < 3; i++) begin
            set_sw(tv[i], uv[i], 4'(i));
            restart;
            `CHK(station_address, 7'(tv[i] * 10 + uv[i]))
            `CHK(bit_rate, 2'(i))
        end
        // switches in range: bus writes of address and rate refused
        obj(`OBJ_CLASS_LINK, `OBJ_ATTR_ADDR, 8'h11);
        obj(`OBJ_CLASS_LINK, `OBJ_ATTR_RATE, 8'h01);
        chk_rd(`REG_STATUS, 16'h0000);
        chk_rd(`REG_ACTIVE, 16'h012A);
    endtask
    // out-of-range and non-decimal switches fall back to stored
    task automatic t_stored;
        set_sw(4'h6, 4'h4, 4'h3);
        wr(`REG_STORED_ADDR, 16'h0015);
        wr(`REG_STORED_RATE, 16'h0001);
        wr(`REG_STORED_RATE, 16'h0003);
        chk_rd(`REG_STORED_RATE, 16'h0001);
        restart;
        `CHK({bit_rate, station_address}, 9'h095)
        set_sw(4'h0, 4'hC, 4'hF);
        restart;
        `CHK({bit_rate, station_address}, 9'h095)
        // tens digit 8: value 85 is out of range, not a wrapped address
        set_sw(4'h8, 4'h5, 4'h3);
        restart;
        `CHK({bit_rate, station_address}, 9'h095)
    endtask
    // bus writes wait for save and restart
    task automatic t_bus;
        obj(`OBJ_CLASS_LINK, `OBJ_ATTR_ADDR, 8'h2A);
        obj(`OBJ_CLASS_LINK, `OBJ_ATTR_RATE, 8'h03);
        chk_rd(`REG_STATUS, 16'h0001);
        obj(`OBJ_CLASS_LINK, `OBJ_ATTR_RATE, 8'h00);
        chk_rd(`REG_STATUS, 16'h0003);
        restart;
        `CHK({bit_rate, station_address}, 9'h095)
        obj(`OBJ_CLASS_STORE, `OBJ_ATTR_SAVE, 8'h00);
        chk_rd(`REG_STORED_ADDR, 16'h002A);
        restart;
        `CHK({bit_rate, station_address}, 9'h02A)
    endtask
    function automatic logic [1:0] lvl(int n);
        return n == 0 ? 2'h0 : n == 10 ? 2'h2 : 2'h1;
    endfunction
    // every led state, code and pins, priority cases included
    task automatic t_led;
        logic [9:0] cv [10] = '{10'h000, 10'h002, 10'h01F, 10'h003,
            10'h00F, 10'h03F, 10'h05F, 10'h0BF, 10'h100, 10'h201};
        logic [2:0] ev [10] = '{`LED_OFF, `LED_OFF, `LED_GREEN,
            `LED_GREEN_BLINK, `LED_GREEN_BLINK, `LED_RED_BLINK,
            `LED_RED_BLINK, `LED_RED, `LED_RED, `LED_RED};
        logic [3:0] pv [10] = '{4'h0, 4'h0, 4'h8, 4'h4, 4'h4, 4'h1,
            4'h1, 4'h2, 4'h2, 4'h2};
        int g, r;
        for (int i = 0; i < 10; i++) begin
            wr(`REG_CTRL, {6'h00, cv[i]});
            g = 0;
            r = 0;
            repeat (10) begin
                @(posedge clk_sys);
                #1 g += (led_green === 1'b1);
                r += (led_red === 1'b1);
            end
            `CHK({lvl(g), lvl(r)}, pv[i])
            chk_rd(`REG_LED, {13'h0000, ev[i]});
        end
    endtask
    // main sequence, with a reset in mid-run
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        #1 t_reset;
        t_switch;
        t_stored;
        t_bus;
        t_led;
        @(posedge clk_sys) rst <= 1'b1;
        @(posedge clk_sys) rst <= 1'b0;
        #1 t_reset;
        results;
    end
    // watchdog against a hang
    initial begin
        repeat (4000) @(posedge clk_sys);
        miscompares++;
        results;
    end
endmodule
